// ### shared/macstx_pkg.sv
package macstx_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_CAPAB = 16'hB000;
    localparam logic [15:0] ADDR_CTRL = 16'hB004;
    localparam logic [15:0] ADDR_SASEL = 16'hB010;
    localparam logic [15:0] ADDR_PN0 = 16'hB018;
    localparam logic [15:0] ADDR_PN1 = 16'hB01C;
    localparam logic [15:0] ADDR_KEY0 = 16'hB020;
    localparam logic [15:0] ADDR_KEY1 = 16'hB030;
    localparam logic [15:0] ADDR_IRQ_STS = 16'hB040;
    localparam logic [15:0] ADDR_IRQ_CLR = 16'hB044;
    localparam logic [15:0] ADDR_IRQ_EN = 16'hB048;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int AN0_LSB = 0;
    localparam int AN1_LSB = 2;
    localparam int SEL_BIT = 4;
    localparam int ACT_BIT = 5;
    localparam int MODE_LSB = 0;
    localparam int PNID_BIT = 2;
    localparam int THR_LSB = 8;
    localparam int IRQ_EXHAUST = 0;
    localparam int IRQ_GUARD = 1;

    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h000007A0;
    localparam logic [31:0] PN_RESET = 32'h00000000;
    localparam logic [31:0] PN_LIMIT = 32'h0000FFFF;
    localparam logic [31:0] PN_GUARD = 32'h0000FFF0;
    localparam logic [7:0] THR_LOW = 8'hFF;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_AUTH = 2'h1;
    localparam logic [1:0] MODE_ENC = 2'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_FRAME = 1'b1
    } macstx_phase_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } macstx_bus_s;

    typedef struct packed {
        logic valid;
        logic [1:0] mode;
        logic [1:0] an;
        logic [31:0] pn;
        logic [127:0] key;
    } macstx_hdr_s;

    typedef struct packed {
        logic [1:0] an0;
        logic [1:0] an1;
        logic sel;
        logic act;
        logic [31:0] ctrl;
        logic [1:0][31:0] pn;
        logic [1:0][3:0][31:0] key;
        logic [1:0] irq_sts;
        logic [1:0] irq_en;
        logic [31:0] rdata;
        macstx_phase_e phase;
        logic frame_sa;
        logic [31:0] frame_pn;
        macstx_hdr_s hdr;
    } macstx_state_s;

endpackage : macstx_pkg

// ### design/macstx_sa_ctx.sv
// Strobed register access was decided locally.
`timescale 1ns/10ps
// Functional notes
// - SA0 active sends association number bits 1:0.
// - SA1 active sends association number bits 3:2.
// - Select bit picks SA, applied at boundaries.
// - Active flag follows select at packet boundary.
// - Active SA packet number goes into header.
// - Software seeds packet number; hardware adds one per frame unless mode is off or control bit 2 is set.
// - Reaching exhaustion threshold raises an interrupt.
// - No packet sent once packet number hits limit.
// - Sending guard packet number forces mode off.
// - Key word n holds key bits 32n+31:32n.
// - Key words read back as zero.
// - Readable digest of keys in capability register.
// - Host order in registers, swapped for frames.
// - Threshold is control bits 31:8 then 0xFF.
// - Mode 00 off, 01 sign, 10 encrypt.
module macstx_sa_ctx
    import macstx_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port.
    input wire macstx_bus_s i_bus,
    output logic [31:0] o_rdata,
    // Transmit path.
    input wire logic i_pkt_sof,
    input wire logic i_pkt_eof,
    output logic o_pkt_stall,
    output macstx_hdr_s o_hdr,
    // Interrupt.
    output logic o_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Reverses the byte order of one word between host and wire order.
    function automatic logic [31:0] bswap32(input logic [31:0] w);
        bswap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : bswap32

    // Tells whether an address falls on a key word of the given base.
    function automatic logic is_key(input logic [15:0] a, input logic [15:0] base);
        is_key = (a[15:4] == base[15:4]);
    endfunction : is_key

    // ----------------------------------------
    // State
    // ----------------------------------------
    macstx_state_s cur;
    macstx_state_s next_cur;
    logic next_sa;
    logic [31:0] next_pn_used;
    logic [31:0] thr;
    logic [31:0] digest;
    logic [31:0] inc_pn;
    logic sof_ok;

    // Exhaustion threshold with its fixed low byte.
    assign thr = {cur.ctrl[31:THR_LSB], THR_LOW};

    // Folds both keys into one word for integrity checks.
    always_comb begin
        digest = 32'h00000000;
        for (int s = 0; s < 2; s++) begin
            for (int n = 0; n < 4; n++) begin
                digest = digest ^ {cur.key[s][n][30:0], cur.key[s][n][31]};
            end
        end
    end

    // The association that the next frame will take.
    assign next_sa = cur.sel;
    assign next_pn_used = cur.pn[next_sa];

    // A frame may start only between frames and while the packet number is not at the limit.
    assign o_pkt_stall = (next_pn_used == PN_LIMIT);
    assign sof_ok = i_pkt_sof && (cur.phase == PH_IDLE) && !o_pkt_stall;
    assign inc_pn = cur.frame_pn + 32'h00000001;

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // Register writes, frame sequencing and hardware updates.
    always_comb begin
        next_cur = cur;
        next_cur.hdr.valid = 1'b0;
        next_cur.rdata = 32'h00000000;

        // Software writes.
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                ADDR_CTRL: next_cur.ctrl = i_bus.wdata;
                ADDR_SASEL: begin
                    next_cur.an0 = i_bus.wdata[AN0_LSB +: 2];
                    next_cur.an1 = i_bus.wdata[AN1_LSB +: 2];
                    next_cur.sel = i_bus.wdata[SEL_BIT];
                end
                ADDR_IRQ_EN: next_cur.irq_en = i_bus.wdata[1:0];
                ADDR_IRQ_CLR: next_cur.irq_sts = cur.irq_sts & ~i_bus.wdata[1:0];
                default: begin
                    if (is_key(i_bus.addr, ADDR_KEY0)) begin
                        next_cur.key[0][i_bus.addr[3:2]] = i_bus.wdata;
                    end
                    if (is_key(i_bus.addr, ADDR_KEY1)) begin
                        next_cur.key[1][i_bus.addr[3:2]] = i_bus.wdata;
                    end
                end
            endcase
        end

        // Frame start latches the association at the packet boundary.
        unique case (cur.phase)
            PH_IDLE: begin
                if (sof_ok) begin
                    next_cur.phase = PH_FRAME;
                    next_cur.act = next_sa;
                    next_cur.frame_sa = next_sa;
                    next_cur.frame_pn = next_pn_used;
                    next_cur.hdr.valid = 1'b1;
                    next_cur.hdr.mode = cur.ctrl[MODE_LSB +: 2];
                    next_cur.hdr.an = next_sa ? cur.an1 : cur.an0;
                    next_cur.hdr.pn = bswap32(next_pn_used);
                    for (int n = 0; n < 4; n++) begin
                        next_cur.hdr.key[32 * n +: 32] = bswap32(cur.key[next_sa][n]);
                    end
                end
            end
            PH_FRAME: begin
                if (i_pkt_eof) begin
                    next_cur.phase = PH_IDLE;
                    if (cur.hdr.mode != MODE_OFF) begin
                        // A software write to the same number in this cycle wins.
                        if (!cur.ctrl[PNID_BIT] && !(i_bus.wr &&
                            i_bus.addr == (cur.frame_sa ? ADDR_PN1 : ADDR_PN0))) begin
                            next_cur.pn[cur.frame_sa] = inc_pn;
                        end
                        if (inc_pn == thr) begin
                            next_cur.irq_sts[IRQ_EXHAUST] = 1'b1;
                        end
                        if (cur.frame_pn == PN_GUARD) begin
                            next_cur.ctrl[MODE_LSB +: 2] = MODE_OFF;
                            next_cur.irq_sts[IRQ_GUARD] = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Packet number writes from software seed the counters.
        if (i_bus.wr && i_bus.addr == ADDR_PN0) begin
            next_cur.pn[0] = i_bus.wdata;
        end
        if (i_bus.wr && i_bus.addr == ADDR_PN1) begin
            next_cur.pn[1] = i_bus.wdata;
        end

        // Read data for the cycle after the strobe.
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                ADDR_CAPAB: next_cur.rdata = digest;
                ADDR_CTRL: next_cur.rdata = cur.ctrl;
                ADDR_SASEL: begin
                    next_cur.rdata[AN0_LSB +: 2] = cur.an0;
                    next_cur.rdata[AN1_LSB +: 2] = cur.an1;
                    next_cur.rdata[SEL_BIT] = cur.sel;
                    next_cur.rdata[ACT_BIT] = cur.act;
                end
                ADDR_PN0: next_cur.rdata = cur.pn[0];
                ADDR_PN1: next_cur.rdata = cur.pn[1];
                ADDR_IRQ_STS: next_cur.rdata = {30'h00000000, cur.irq_sts};
                ADDR_IRQ_EN: next_cur.rdata = {30'h00000000, cur.irq_en};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------

    // Holds the whole block state.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
            cur.ctrl <= CTRL_RESET;
            cur.pn <= {PN_RESET, PN_RESET};
            cur.phase <= PH_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Read data, header and interrupt level.
    assign o_rdata = cur.rdata;
    assign o_hdr = cur.hdr;
    assign o_irq = |(cur.irq_sts & cur.irq_en);

endmodule : macstx_sa_ctx

// ### sim/macstx_sa_ctx_properties.sv
`timescale 1ns/10ps
module macstx_sa_ctx_chk
    import macstx_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Watched ports.
    input wire macstx_bus_s i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic i_pkt_sof,
    input wire logic i_pkt_eof,
    input wire logic o_pkt_stall,
    input wire macstx_hdr_s o_hdr,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic open_q;
    logic take;
    // A start is taken only while idle and not stalled.
    assign take = i_pkt_sof && !open_q && !o_pkt_stall;
    // Tracks whether a frame is open.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) open_q <= 1'b0;
        else open_q <= take | (open_q & ~i_pkt_eof);
    end
    // -------------------------------------
    // Properties
    // -------------------------------------
    chk_sof_header: assert property (take |=> o_hdr.valid)
        else $error("no header after start");
    chk_header_cause: assert property (o_hdr.valid |-> $past(take))
        else $error("header without start");
    chk_stall_refuse: assert property (i_pkt_sof && o_pkt_stall |=> !o_hdr.valid)
        else $error("start taken at limit");
    chk_valid_single: assert property (o_hdr.valid |=> !o_hdr.valid)
        else $error("header valid too long");
    chk_an_hold: assert property (!o_hdr.valid |-> $stable(o_hdr.an))
        else $error("number changed mid frame");
    chk_pn_hold: assert property (!o_hdr.valid |-> $stable(o_hdr.pn))
        else $error("packet number changed mid frame");
    chk_key_hold: assert property (!o_hdr.valid |-> $stable(o_hdr.key))
        else $error("key changed mid frame");
    chk_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data without read");
    chk_irq_cause: assert property ($rose(o_irq) |-> $past(i_pkt_eof || i_bus.wr))
        else $error("interrupt without cause");
    cover property (take);
    cover property ($rose(o_irq));
    cover property (i_pkt_sof && o_pkt_stall);
endmodule : macstx_sa_ctx_chk

bind macstx_sa_ctx macstx_sa_ctx_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_pkt_sof(i_pkt_sof), .i_pkt_eof(i_pkt_eof),
    .o_pkt_stall(o_pkt_stall), .o_hdr(o_hdr), .o_irq(o_irq));

// ### sim/test_macstx_sa_ctx.sv
`timescale 1ns/10ps
module test_macstx_sa_ctx
    import macstx_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    macstx_bus_s bus = '0;
    logic sof = 1'b0;
    logic eof = 1'b0;
    logic [31:0] o_rdata;
    logic o_pkt_stall;
    macstx_hdr_s o_hdr;
    logic o_irq;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] kw;
    logic [127:0] kexp;
    logic [31:0] dig = 32'h0;

    // Clock of 8 ns period.
    always #4 i_clk = ~i_clk;

    macstx_sa_ctx DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(o_rdata),
        .i_pkt_sof(sof), .i_pkt_eof(eof), .o_pkt_stall(o_pkt_stall), .o_hdr(o_hdr),
        .o_irq(o_irq));

    // -------------------------------------
    // Helpers
    // -------------------------------------
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        bus <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge i_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge i_clk);
        bus <= '0;
        #1 chk(o_rdata, e);
    endtask : rd

    function automatic logic [31:0] sw(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : sw

    // Sends one frame and checks the header it produced.
    task automatic frame(input logic v, input logic [1:0] an, input logic [31:0] pn);
        @(posedge i_clk);
        sof <= 1'b1;
        @(posedge i_clk);
        sof <= 1'b0;
        #1 chk(o_hdr.valid, v);
        if (v) begin
            chk(o_hdr.an, an);
            chk(o_hdr.pn, sw(pn));
        end
        @(posedge i_clk);
        eof <= 1'b1;
        @(posedge i_clk);
        eof <= 1'b0;
    endtask : frame

    task automatic complete_run();
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // -------------------------------------
    // Tests
    // -------------------------------------
    // Main sequence of register and frame traffic.
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(ADDR_SASEL, 32'h0);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_PN0, PN_RESET);
        for (int n = 0; n < 4; n++) begin
            kw = 32'hA1B2C3D4 + 32'(n) * 32'h01010101;
            wr(ADDR_KEY0 + 16'(4 * n), kw);
            rd(ADDR_KEY0 + 16'(4 * n), 32'h0);
            kexp[32 * n +: 32] = sw(kw);
            dig = dig ^ {kw[30:0], kw[31]};
        end
        rd(ADDR_CAPAB, dig);
        wr(ADDR_CTRL, CTRL_RESET | 32'(MODE_ENC));
        wr(ADDR_SASEL, 32'h9);
        wr(ADDR_PN0, 32'h5);
        wr(ADDR_PN1, 32'h7FE);
        wr(ADDR_IRQ_EN, 32'h1);
        frame(1'b1, 2'h1, 32'h5);
        chk(o_hdr.key, kexp);
        chk(o_hdr.mode, MODE_ENC);
        rd(ADDR_PN0, 32'h6);
        rd(ADDR_PN1, 32'h7FE);
        wr(ADDR_SASEL, 32'h19);
        rd(ADDR_SASEL, 32'h19);
        frame(1'b1, 2'h2, 32'h7FE);
        rd(ADDR_SASEL, 32'h39);
        chk(o_irq, 1'b1);
        rd(ADDR_IRQ_STS, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1);
        rd(ADDR_IRQ_STS, 32'h0);
        chk(o_irq, 1'b0);
        wr(ADDR_PN1, PN_GUARD);
        frame(1'b1, 2'h2, PN_GUARD);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_IRQ_STS, 32'h2);
        chk(o_irq, 1'b0);
        frame(1'b1, 2'h2, PN_GUARD + 32'h1);
        chk(o_hdr.mode, MODE_OFF);
        wr(ADDR_PN1, PN_LIMIT);
        rd(ADDR_PN1, PN_LIMIT);
        chk(o_pkt_stall, 1'b1);
        frame(1'b0, 2'h2, PN_LIMIT);
        rd(16'hB100, 32'h0);
        wr(ADDR_PN1, 32'h10);
        wr(ADDR_CTRL, CTRL_RESET | 32'(MODE_AUTH) | 32'h4);
        frame(1'b1, 2'h2, 32'h10);
        chk(o_hdr.mode, MODE_AUTH);
        rd(ADDR_PN1, 32'h10);
        complete_run();
    end

    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge i_clk);
        num_errors++;
        complete_run();
    end
endmodule : test_macstx_sa_ctx
